// ===== src/sdc_regs.svh
// Constants of the serial DAC control link: frame fields, reset codes, timing.
// Assumes inclusion by bare name from the src folder.
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

`define SDC_SHIFT_BITS 32
`define SDC_SHORT_FRAME 24
`define SDC_LONG_FRAME 32
`define SDC_CMD_MSB 23
`define SDC_CMD_LSB 20
`define SDC_DATA_MSB 15
`define SDC_FIELD_BITS 16
`define SDC_ZERO_CODE 16'h0000
`define SDC_MID_CODE 16'h8000
`define SDC_CLK_PERIOD_NS 10
`define SDC_SCK_HALF_NS 80
`define SDC_SCK_HALF_CYCLES ((`SDC_SCK_HALF_NS + `SDC_CLK_PERIOD_NS - 1) / `SDC_CLK_PERIOD_NS)

`endif

// ===== src/sdc_pkg.sv
// Types shared by both ends of the serial DAC control link.
// Assumes the constants header is compiled alongside.
`default_nettype none
package sdc_pkg;
  typedef enum logic [3:0] {
    SDC_CMD_WRITE = 4'h0,
    SDC_CMD_UPDATE = 4'h1,
    SDC_CMD_WRITE_UPDATE = 4'h3,
    SDC_CMD_POWER_DOWN = 4'h4,
    SDC_CMD_NOP = 4'hF
  } sdc_cmd_t;

  typedef enum logic [4:0] {
    SDC_H_IDLE = 5'h01,
    SDC_H_SETUP = 5'h02,
    SDC_H_LOW = 5'h04,
    SDC_H_HIGH = 5'h08,
    SDC_H_FINISH = 5'h10
  } sdc_host_state_t;
endpackage
`default_nettype wire

// ===== src/sdc_link_if.sv
// Three-wire link plus update, clear and daisy-chain pins between host and DAC.
// Assumes the bench joins both modports; all wires are one-way.
`default_nettype none
interface sdc_link_if;
  logic sck;
  logic serial_in;
  logic select_load_n;
  logic async_update_n;
  logic async_clear_n;
  logic chain_serial_out;

  modport device (
    input sck,
    input serial_in,
    input select_load_n,
    input async_update_n,
    input async_clear_n,
    output chain_serial_out
  );

  modport host (
    output sck,
    output serial_in,
    output select_load_n,
    output async_update_n,
    output async_clear_n,
    input chain_serial_out
  );
endinterface
`default_nettype wire

// ===== src/sdc_sync.sv
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherence across bits.
`default_nettype none
module sdc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ===== src/sdc_device.sv
// Digital control of a single-channel serial DAC: shift, input and DAC registers.
// Assumes link pins are asynchronous to mclk_in and change far slower than it.
//
// Behaviour
// R1 - Chain output: bit appears 32 edges later
// R2 - Chain output always driven, never released
// R3 - Serial input sampled on shift-clock rising edges
// R4 - Accept 24-bit or 32-bit frames
// R5 - Clear low forces registers to reset code
// R6 - Shift only while select/load strobe low
// R7 - Update fall with strobe high updates DAC
// R8 - Update fall with strobe low waits
// R9 - Update input low powers DAC up
// R10 - Update low blocks power-down command
// R11 - Power-on registers hold reset code
// R12 - Frame: command, four ignored, sixteen data
// R13 - Data left-justified, trailing bits ignored
// R14 - Strobe rise executes last 24 bits
// R15 - Write loads input register only
// R16 - Update copies input, powers up DAC
// R17 - Long frame: eight ignored bits first
// R18 - Decode write, update, both, power-down, nop
// R19 - Host sends nop to untouched chain devices
// R20 - Power-down keeps both registers intact
// R21 - Reserved codes act as no-operation
`include "sdc_regs.svh"
`default_nettype none
module sdc_device #(
  parameter int RES_BITS = 16,
  parameter bit MIDSCALE_RESET = 1'b0
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  sdc_link_if.device link,
  output logic [RES_BITS-1:0] dac_code_out,
  output logic [RES_BITS-1:0] input_code_out,
  output logic dac_powered_out,
  output logic update_pending_out,
  output logic [3:0] last_cmd_out,
  output logic [5:0] frame_bits_out,
  output logic frame_short_out
);
  // Left-justified code: keep the top RES_BITS of the data field
  function automatic logic [RES_BITS-1:0] code_of(input logic [`SDC_FIELD_BITS-1:0] field);
    code_of = field[`SDC_FIELD_BITS-1 -: RES_BITS];
  endfunction

  localparam logic [RES_BITS-1:0] RST_CODE = code_of(MIDSCALE_RESET ? `SDC_MID_CODE : `SDC_ZERO_CODE);

  // Every pin is two-flopped before any logic reads it
  logic [4:0] pins_s;
  sdc_sync #(
    .WIDTH(5),
    .RST_VAL(5'h1C)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .async_in({link.async_clear_n, link.async_update_n, link.select_load_n, link.serial_in, link.sck}),
    .sync_out(pins_s)
  );

  wire sck_s = pins_s[0];
  wire sdi_s = pins_s[1];
  wire sel_n_s = pins_s[2];
  wire upd_n_s = pins_s[3];
  wire clr_n_s = pins_s[4];

  logic sck_p_q;
  logic sel_p_q;
  logic upd_p_q;
  logic [`SDC_SHIFT_BITS-1:0] shift_q;
  logic [`SDC_SHIFT_BITS-1:0] shift_d;
  logic [RES_BITS-1:0] input_q;
  logic [RES_BITS-1:0] input_d;
  logic [RES_BITS-1:0] dac_q;
  logic [RES_BITS-1:0] dac_d;
  logic pwr_q;
  logic pwr_d;
  logic pend_q;
  logic pend_d;
  logic chain_q;
  logic chain_d;
  logic [5:0] count_q;
  logic [5:0] count_d;
  logic [3:0] last_cmd_q;
  logic [3:0] last_cmd_d;
  logic [5:0] bits_q;
  logic [5:0] bits_d;
  logic short_q;
  logic short_d;

  // Edge detection on synchronised copies only
  wire sck_rise = sck_s & ~sck_p_q;
  wire sck_fall = ~sck_s & sck_p_q;
  wire sel_rise = sel_n_s & ~sel_p_q;
  wire sel_fall = ~sel_n_s & sel_p_q;
  wire upd_fall = ~upd_n_s & upd_p_q;
  wire clearing = ~clr_n_s;

  // Edges seen with the strobe high are dropped, so a shared clock cannot disturb an idle frame
  wire shift_en = sck_rise & ~sel_n_s; // R3 R6
  wire chain_en = sck_fall & ~sel_n_s; // R1

  // Command and data always sit in the low 24 bits; any eight leading bits of a long frame sit in the top byte, which is never decoded
  wire [3:0] cmd = shift_q[`SDC_CMD_MSB:`SDC_CMD_LSB]; // R4 R12 R14 R17
  wire [RES_BITS-1:0] new_code = code_of(shift_q[`SDC_DATA_MSB:0]); // R12 R13

  wire cmd_write = (cmd == sdc_pkg::SDC_CMD_WRITE) | (cmd == sdc_pkg::SDC_CMD_WRITE_UPDATE); // R18
  wire cmd_update = (cmd == sdc_pkg::SDC_CMD_UPDATE) | (cmd == sdc_pkg::SDC_CMD_WRITE_UPDATE); // R18
  wire cmd_pd = (cmd == sdc_pkg::SDC_CMD_POWER_DOWN); // R18

  wire do_write = sel_rise & cmd_write; // R14 R15
  wire do_sw_update = sel_rise & cmd_update; // R16
  wire do_late_update = sel_rise & pend_q; // R8
  wire do_now_update = upd_fall & sel_n_s; // R7
  wire do_update = do_sw_update | do_late_update | do_now_update;
  // Power-down is refused whenever the update pin is low
  wire do_pd = sel_rise & cmd_pd & upd_n_s; // R10 R20

  // A write and an update in one execution use the freshly written code
  wire [RES_BITS-1:0] update_src = do_write ? new_code : input_q;

  // Clear is a level: the codes stay forced for as long as the pin is low
  assign input_d = clearing ? RST_CODE : (do_write ? new_code : input_q); // R5 R15 R21
  assign dac_d = clearing ? RST_CODE : (do_update ? update_src : dac_q); // R5 R7 R16 R21
  // A low update pin outranks a power-down in the same cycle
  assign pwr_d = (~upd_n_s | do_update) ? 1'b1 : (do_pd ? 1'b0 : pwr_q); // R9 R16 R10
  // Set needs the strobe low and clear needs its rise, so the two never meet
  assign pend_d = clearing ? 1'b0 : ((upd_fall & ~sel_n_s) ? 1'b1 : (sel_rise ? 1'b0 : pend_q)); // R8
  assign shift_d = clearing ? '0 : (shift_en ? {shift_q[`SDC_SHIFT_BITS-2:0], sdi_s} : shift_q); // R5 R3 R6
  assign chain_d = chain_en ? shift_q[`SDC_SHIFT_BITS-1] : chain_q; // R1
  // Saturates so an overlong frame cannot wrap back to a legal length
  assign count_d = sel_fall ? 6'h00 : ((shift_en & (count_q != 6'h3F)) ? count_q + 6'h01 : count_q);

  // Snapshot of the finished frame, taken at the strobe rise
  assign last_cmd_d = sel_rise ? cmd : last_cmd_q;
  assign bits_d = sel_rise ? count_q : bits_q;
  assign short_d = sel_rise ? (count_q < 6'(`SDC_SHORT_FRAME)) : short_q;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sck_p_q <= 1'b0;
      sel_p_q <= 1'b1;
      upd_p_q <= 1'b1;
    end else begin
      sck_p_q <= sck_s;
      sel_p_q <= sel_n_s;
      upd_p_q <= upd_n_s;
    end
  end

  // Held codes; both start from the reset code
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      input_q <= RST_CODE; // R11
      dac_q <= RST_CODE; // R11
    end else begin
      input_q <= input_d;
      dac_q <= dac_d;
    end
  end

  // Shift register and chain output stage
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_q <= '0;
      chain_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      chain_q <= chain_d;
    end
  end

  // Power state and postponed update
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pwr_q <= 1'b1;
      pend_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      pend_q <= pend_d;
    end
  end

  // Frame bookkeeping for observation; execution never depends on it
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= 6'h00;
      last_cmd_q <= 4'hF;
      bits_q <= 6'h00;
      short_q <= 1'b0;
    end else begin
      count_q <= count_d;
      last_cmd_q <= last_cmd_d;
      bits_q <= bits_d;
      short_q <= short_d;
    end
  end

  // Plain output with no enable: the pin stays driven even with the strobe high
  assign link.chain_serial_out = chain_q; // R2
  assign dac_code_out = dac_q;
  assign input_code_out = input_q;
  assign dac_powered_out = pwr_q;
  assign update_pending_out = pend_q;
  assign last_cmd_out = last_cmd_q;
  assign frame_bits_out = bits_q;
  assign frame_short_out = short_q;
endmodule
`default_nettype wire

// ===== src/sdc_host.sv
// Host end: makes the shift clock by division and sends one 24- or 32-bit frame.
// Assumes the user holds update and clear levels; start is honoured only when idle.
`include "sdc_regs.svh"
`default_nettype none
module sdc_host (
  input wire logic mclk_in,
  input wire logic rst_in,
  sdc_link_if.host link,
  input wire logic start_in,
  input wire logic [31:0] word_in,
  input wire logic long_frame_in,
  input wire logic update_n_in,
  input wire logic clear_n_in,
  output logic busy_out,
  output logic done_out,
  output logic [31:0] readback_out
);
  localparam logic [7:0] HALF = 8'(`SDC_SCK_HALF_CYCLES);

  sdc_pkg::sdc_host_state_t state_q;
  logic [7:0] tick_q;
  logic [5:0] bits_q;
  logic [31:0] tx_q;
  logic [31:0] rx_q;
  logic [31:0] readback_q;
  logic sck_q;
  logic sdi_q;
  logic sel_n_q;
  logic upd_n_q;
  logic clr_n_q;
  logic done_q;
  logic chain_s;

  sdc_sync #(
    .WIDTH(1),
    .RST_VAL(1'h0)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .async_in(link.chain_serial_out),
    .sync_out(chain_s)
  );

  wire tick_done = (tick_q == 8'h00);
  // Short frames are left-aligned so their command leaves first; a long frame leads with its top byte
  wire [31:0] tx_load = long_frame_in ? word_in : {word_in[23:0], 8'h00}; // R12 R17
  wire [5:0] bits_load = long_frame_in ? 6'(`SDC_LONG_FRAME) : 6'(`SDC_SHORT_FRAME);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      upd_n_q <= 1'b1;
      clr_n_q <= 1'b1;
    end else begin
      upd_n_q <= update_n_in;
      clr_n_q <= clear_n_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= sdc_pkg::SDC_H_IDLE;
      tick_q <= 8'h00;
      bits_q <= 6'h00;
      tx_q <= 32'h0000_0000;
      rx_q <= 32'h0000_0000;
      readback_q <= 32'h0000_0000;
      sck_q <= 1'b0;
      sdi_q <= 1'b0;
      sel_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      tick_q <= tick_done ? 8'h00 : tick_q - 8'h01;
      case (state_q)
        sdc_pkg::SDC_H_IDLE: begin
          if (start_in) begin
            tx_q <= tx_load;
            bits_q <= bits_load;
            sel_n_q <= 1'b0;
            sck_q <= 1'b0;
            tick_q <= HALF - 8'h01;
            state_q <= sdc_pkg::SDC_H_SETUP;
          end
        end
        sdc_pkg::SDC_H_SETUP: begin
          if (tick_done) begin
            sdi_q <= tx_q[31];
            tx_q <= {tx_q[30:0], 1'b0};
            tick_q <= HALF - 8'h01;
            state_q <= sdc_pkg::SDC_H_LOW;
          end
        end
        sdc_pkg::SDC_H_LOW: begin
          // Data has stood a whole half period before the rising edge
          if (tick_done) begin
            sck_q <= 1'b1; // R3
            rx_q <= {rx_q[30:0], chain_s};
            tick_q <= HALF - 8'h01;
            state_q <= sdc_pkg::SDC_H_HIGH;
          end
        end
        sdc_pkg::SDC_H_HIGH: begin
          if (tick_done) begin
            sck_q <= 1'b0;
            bits_q <= bits_q - 6'h01;
            tick_q <= HALF - 8'h01;
            if (bits_q == 6'h01) begin
              state_q <= sdc_pkg::SDC_H_FINISH;
            end else begin
              sdi_q <= tx_q[31]; // R13
              tx_q <= {tx_q[30:0], 1'b0};
              state_q <= sdc_pkg::SDC_H_LOW;
            end
          end
        end
        sdc_pkg::SDC_H_FINISH: begin
          if (tick_done) begin
            sel_n_q <= 1'b1;
            done_q <= 1'b1;
            readback_q <= rx_q;
            state_q <= sdc_pkg::SDC_H_IDLE;
          end
        end
        default: begin
          state_q <= sdc_pkg::SDC_H_IDLE;
        end
      endcase
    end
  end

  assign link.sck = sck_q;
  assign link.serial_in = sdi_q;
  assign link.select_load_n = sel_n_q;
  assign link.async_update_n = upd_n_q;
  assign link.async_clear_n = clr_n_q;
  assign busy_out = ~state_q[0];
  assign done_out = done_q;
  assign readback_out = readback_q;
endmodule
`default_nettype wire

// ===== testbench/sdc_link_assertions.sv
// Checker of the link wires between host and device ends.
// Assumes the bench hands it the interface wires and the host clock domain.
`default_nettype none
module sdc_link_assertions (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic sck,
  input wire logic serial_in,
  input wire logic select_load_n,
  input wire logic async_update_n,
  input wire logic async_clear_n,
  input wire logic chain_serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic sck_q;
  logic sel_q;
  logic [5:0] rise_q;
  wire logic [5:0] rise_d;
  // Count rises per frame, cleared once the strobe has stayed high
  assign rise_d = select_load_n ? (sel_q ? 6'h00 : rise_q) : rise_q + {5'h00, sck & ~sck_q};
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sck_q <= 1'b0;
      sel_q <= 1'b1;
      rise_q <= 6'h00;
    end else begin
      sck_q <= sck;
      sel_q <= select_load_n;
      rise_q <= rise_d;
    end
  end
  sequence s_high_phase;
    sck [*8] ##1 !sck;
  endsequence
  sequence s_lead;
    !sck [*8];
  endsequence
  property p_sck_quiet;
    select_load_n |-> !sck;
  endproperty
  property p_sdi_hold;
    sck && $past(sck) |-> $stable(serial_in);
  endproperty
  property p_sck_high;
    $rose(sck) |-> s_high_phase;
  endproperty
  property p_frame_lead;
    $fell(select_load_n) |-> s_lead;
  endproperty
  // A little slack on the sync delay, but a change off a rising edge still fails
  property p_sdo_timing;
    $changed(chain_serial_out) |-> ($past(sck, 4) && !$past(sck, 3)) || ($past(sck, 3) && !$past(sck, 2))
      || ($past(sck, 5) && !$past(sck, 4));
  endproperty
  property p_sdo_steady;
    select_load_n && $past(select_load_n) |-> $stable(chain_serial_out);
  endproperty
  property p_sel_gap;
    $rose(select_load_n) |-> !$past(sck, 1) && !$past(sck, 7);
  endproperty
  property p_frame_len;
    $rose(select_load_n) |-> rise_q == 6'h18 || rise_q == 6'h20;
  endproperty
  property p_upd_pulse;
    $fell(async_update_n) |-> !async_update_n [*3];
  endproperty
  property p_clr_pulse;
    $fell(async_clear_n) |-> !async_clear_n [*3];
  endproperty
  a_sck_quiet: assert property (p_sck_quiet) else $error("shift clock active with strobe high");
  a_sdi_hold: assert property (p_sdi_hold) else $error("serial input moved while clock high");
  a_sck_high: assert property (p_sck_high) else $error("clock high phase not 8 cycles");
  a_frame_lead: assert property (p_frame_lead) else $error("clock rose too soon after strobe fall");
  a_sdo_timing: assert property (p_sdo_timing) else $error("chain output moved off a falling edge");
  a_sdo_steady: assert property (p_sdo_steady) else $error("chain output moved with strobe high");
  a_sel_gap: assert property (p_sel_gap) else $error("strobe rose too close to clock");
  a_frame_len: assert property (p_frame_len) else $error("frame not 24 or 32 bits");
  a_upd_pulse: assert property (p_upd_pulse) else $error("update pin low for under 3 cycles");
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear pin low for under 3 cycles");
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Top bench: host end and device end joined by the link interface.
// Assumes the design files and constants header are compiled first.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic go = 1'b0;
  logic [31:0] word = 32'h0;
  logic lng = 1'b0;
  logic upd_n = 1'b1;
  logic clr_n = 1'b1;
  logic busy, done, pwr, pend, fshort;
  logic [31:0] rdbk;
  logic [15:0] dac, inp;
  logic [3:0] lcmd;
  logic [5:0] fbits;
  int bad_count = 0;
  int checks = 0;
  sdc_link_if i_sdc_link_if ();
  sdc_host i_sdc_host (.mclk_in(mclk_in), .rst_in(rst_in), .link(i_sdc_link_if.host), .start_in(go),
    .word_in(word), .long_frame_in(lng), .update_n_in(upd_n), .clear_n_in(clr_n), .busy_out(busy),
    .done_out(done), .readback_out(rdbk));
  sdc_device #(.RES_BITS(16), .MIDSCALE_RESET(1'b0)) i_sdc_device (.mclk_in(mclk_in), .rst_in(rst_in),
    .link(i_sdc_link_if.device), .dac_code_out(dac), .input_code_out(inp), .dac_powered_out(pwr),
    .update_pending_out(pend), .last_cmd_out(lcmd), .frame_bits_out(fbits), .frame_short_out(fshort));
  sdc_link_assertions i_sdc_link_assertions (.mclk_in(mclk_in), .rst_in(rst_in), .sck(i_sdc_link_if.sck),
    .serial_in(i_sdc_link_if.serial_in), .select_load_n(i_sdc_link_if.select_load_n),
    .async_update_n(i_sdc_link_if.async_update_n), .async_clear_n(i_sdc_link_if.async_clear_n),
    .chain_serial_out(i_sdc_link_if.chain_serial_out));
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ws(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask
  // Registers settle 3 cycles after the strobe rise; 6 leaves margin
  task automatic send(input logic [3:0] c, input logic [15:0] d, input logic [7:0] lead, input logic l,
    input logic pulse);
    int n;
    @(posedge mclk_in);
    go <= 1'b1;
    word <= {lead, c, 4'h0, d};
    lng <= l;
    @(posedge mclk_in);
    go <= 1'b0;
    ws(1);
    chk(busy, 1'b1);
    if (pulse) begin
      ws(100);
      @(posedge mclk_in);
      upd_n <= 1'b0;
      ws(6);
      chk(pend, 1'b1);
      @(posedge mclk_in);
      upd_n <= 1'b1;
    end
    n = 0;
    do begin
      ws(1);
      n++;
    end while (done !== 1'b1 && n < 1000);
    if (n >= 1000) bad_count++;
    chk(busy, 1'b0);
    ws(6);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset;
    ws(1);
    chk(dac, 16'h0000);
    chk(inp, 16'h0000);
    chk(lcmd, 4'hF);
    chk(i_sdc_link_if.chain_serial_out, 1'b0);
  endtask
  task automatic t_write_update;
    send(4'h0, 16'h1234, 8'h00, 1'b0, 1'b0);
    chk(inp, 16'h1234);
    chk(dac, 16'h0000);
    chk(fbits, 6'h18);
    chk(fshort, 1'b0);
    send(4'h1, 16'h0000, 8'h00, 1'b0, 1'b0);
    chk(dac, 16'h1234);
    chk(inp, 16'h1234);
  endtask
  task automatic t_long_chain;
    send(4'h3, 16'hBEEF, 8'hA5, 1'b1, 1'b0);
    chk(dac, 16'hBEEF);
    chk(fbits, 6'h20);
    send(4'hF, 16'h0000, 8'h00, 1'b1, 1'b0);
    chk(rdbk, 32'hA530BEEF);
    chk(dac, 16'hBEEF);
    chk(lcmd, 4'hF);
  endtask
  task automatic t_power;
    send(4'h4, 16'hFFFF, 8'h00, 1'b0, 1'b0);
    chk(pwr, 1'b0);
    chk(inp, 16'hBEEF);
    chk(dac, 16'hBEEF);
    for (int c = 2; c < 15; c++) begin
      if (c != 3 && c != 4) begin
        send(c[3:0], 16'h0001, 8'h00, 1'b0, 1'b0);
        chk(pwr, 1'b0);
        chk({inp, dac}, {16'hBEEF, 16'hBEEF});
      end
    end
    send(4'h3, 16'h4321, 8'h00, 1'b0, 1'b0);
    chk({pwr, dac}, {1'b1, 16'h4321});
  endtask
  task automatic t_async;
    send(4'h0, 16'h5A5A, 8'h00, 1'b0, 1'b0);
    send(4'h4, 16'h0000, 8'h00, 1'b0, 1'b0);
    @(posedge mclk_in);
    upd_n <= 1'b0;
    ws(6);
    chk(dac, 16'h5A5A);
    chk(pwr, 1'b1);
    send(4'h4, 16'h0000, 8'h00, 1'b0, 1'b0);
    chk(pwr, 1'b1);
    @(posedge mclk_in);
    upd_n <= 1'b1;
    ws(6);
    chk(pwr, 1'b1);
    send(4'h0, 16'h7777, 8'h00, 1'b0, 1'b1);
    chk({pend, dac}, {1'b0, 16'h7777});
  endtask
  task automatic t_clear;
    @(posedge mclk_in);
    clr_n <= 1'b0;
    ws(6);
    chk({inp, dac}, 32'h0);
    chk(i_sdc_link_if.chain_serial_out === 1'b0 || i_sdc_link_if.chain_serial_out === 1'b1, 1'b1);
    @(posedge mclk_in);
    clr_n <= 1'b1;
  endtask
  initial begin
    ws(20);
    @(posedge mclk_in);
    rst_in <= 1'b0;
    t_reset();
    t_write_update();
    t_long_chain();
    t_power();
    t_async();
    t_clear();
    close_out();
  end
  // About 20 frames of some 420 cycles, near 9k cycles; 20k cycles is ample
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
